// file: imp_defines.svh
// Constants for the indexed move and push literal execution block
`ifndef IMP_DEFINES_SVH
`define IMP_DEFINES_SVH

`define IMP_ADDR_W        12
`define IMP_DATA_W        8
`define IMP_OFS_W         7
`define IMP_ADDR_MAX      12'h0FFF
`define IMP_FP_RESET      12'h0000
`define IMP_SRC_ZERO      8'h00
// Indirect-addressing registers (indirect, post-dec, post-inc, pre-inc, plusw)
`define IMP_IND_LO        12'h0FD9
`define IMP_IND_HI        12'h0FEF
`define IMP_IND_STEP      12'h0008
`define IMP_IND_SPAN      12'h0004
`define IMP_PCL_ADDR      12'h0FF9
`define IMP_TOP_OF_STACK_LOW_ADDR     12'h0FFD
`define IMP_TOP_OF_STACK_HIGH_ADDR     12'h0FFE
`define IMP_TOP_OF_STACK_UPPER_ADDR     12'h0FFF

`endif

// file: imp_pkg.sv
// Types for the indexed move and push literal execution block
package imp_pkg;

    typedef enum logic [1:0] {
        IMP_IDLE,
        IMP_MOVE_RD,
        IMP_MOVE_WR
    } imp_state_t;

    typedef struct packed {
        logic        move_go;
        logic [6:0]  src_ofs;
        logic [6:0]  dst_ofs;
        logic        push_go;
        logic [7:0]  literal;
    } imp_cmd_t;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } imp_mem_t;

    typedef struct packed {
        imp_state_t  state;
        logic [11:0] frame_pointer_reg;
        logic [11:0] dst_addr;
        logic        dst_bad;
        imp_mem_t    mem;
        logic        done;
        logic        nop;
    } imp_regs_t;

endpackage

// file: imp_exec.sv
// Executes the indexed-to-indexed move and the push literal instructions
`include "imp_defines.svh"

// ****************************************
// Timing
// ****************************************
// Edges are counted from the edge on which a request is taken.
// Push: taken on the edge where the block is idle and push_go is high.
//   +1 write strobe, the old pointer as address, the literal as data,
//      done high, and the pointer already one lower.
//   Pushes may follow each other on every clock.
// Move: taken on the edge where the block is idle, push_go is low and
//   move_go is high. Push wins when both are raised together.
//   +1 read strobe with the source address, busy high
//   +2 read strobe held, memory presents the source byte
//   +3 write strobe with the destination address, done, busy low
// The read data is sampled on the edge that leaves the second read
//   cycle, so a synchronous memory with one cycle of latency fits.
// Requests raised while busy are dropped without any indication.
//   A move must therefore wait for busy to fall.
// A pointer load is taken only while idle; a push in the same cycle
//   wins and decrements the old pointer.
// Indirect registers come in three banks of five, one bank every
//   eight addresses. A source there reads as zero and no memory read
//   is issued; a destination there turns the move into a no-operation
//   that still pulses done, together with nop.
// Addresses wrap modulo 4096, so offsets past the top land low.
// Writes to the program counter or stack bytes are not caught here:
//   the program must not aim a move at them.
// Reset is synchronous and active low: strobes and pulses low, the
//   pointer at 000h, and the first request taken on the first edge
//   after release.
// done, nop and the write strobe are one-cycle pulses; the read strobe
//   stands two cycles; address and data hold until the next access.
// Neither instruction touches any status flag.

module imp_exec (
    // Clock and reset
    input  wire logic            clk_i,
    input  wire logic            resetn_i,
    // Decoded instruction
    input  wire imp_pkg::imp_cmd_t cmd_i,
    // Frame pointer load from register file
    input  wire logic            fp_load_i,
    input  wire logic [11:0]     fp_value_i,
    // Data memory
    output imp_pkg::imp_mem_t    mem_o,
    input  wire logic [7:0]      mem_rdata_i,
    // Status
    output logic                 busy_o,
    output logic                 done_o,
    output logic                 nop_o,
    output logic [11:0]          frame_pointer_reg_o
);

    // ****************************************
    // Address helpers
    // ****************************************
    function automatic logic [11:0] fp_plus(input logic [11:0] fp,
                                            input logic [6:0] ofs);
        fp_plus = 12'(fp + {5'h0_0, ofs});
    endfunction

    // One bank of indirect registers: five addresses from its base
    function automatic logic in_bank(input logic [11:0] a,
                                     input logic [11:0] base);
        logic [11:0] rel;
        rel = 12'(a - base);
        in_bank = (a >= base) && (rel <= `IMP_IND_SPAN);
    endfunction

    // Any indirect register, whatever its access flavour
    function automatic logic is_indirect(input logic [11:0] a);
        logic [11:0] base0;
        logic [11:0] base1;
        logic [11:0] base2;
        base0 = `IMP_IND_LO;
        base1 = 12'(`IMP_IND_LO + `IMP_IND_STEP);
        base2 = 12'(`IMP_IND_LO + (`IMP_IND_STEP << 1));
        is_indirect = in_bank(a, base0)
                      || in_bank(a, base1)
                      || in_bank(a, base2);
    endfunction

    // ****************************************
    // State
    // ****************************************
    imp_pkg::imp_regs_t r;
    imp_pkg::imp_regs_t next_r;

    // ****************************************
    // Request decode
    // ****************************************
    logic        idle;
    logic        take_push;
    logic        take_move;
    logic        take_load;

    assign idle = (r.state == imp_pkg::IMP_IDLE);
    // Push has priority over move in the same cycle
    assign take_push = idle && cmd_i.push_go;
    assign take_move = idle && !cmd_i.push_go && cmd_i.move_go;
    assign take_load = idle && fp_load_i;

    // ****************************************
    // Datapath
    // ****************************************
    logic [11:0] move_src;
    logic [11:0] move_dst;
    logic        src_ind;
    logic        dst_ind;
    logic [11:0] fp_dec;
    logic [7:0]  move_byte;
    logic        move_we;
    logic        move_nop;

    assign move_src = fp_plus(r.frame_pointer_reg, cmd_i.src_ofs);
    assign move_dst = fp_plus(r.frame_pointer_reg, cmd_i.dst_ofs);
    assign src_ind = is_indirect(move_src);
    assign dst_ind = is_indirect(move_dst);
    assign fp_dec = 12'(r.frame_pointer_reg - 12'h0001);
    // Source byte as captured at the end of the second read cycle
    assign move_byte = r.mem.re ? mem_rdata_i : `IMP_SRC_ZERO;
    assign move_we = ~r.dst_bad;
    assign move_nop = r.dst_bad;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_r = r;
        // Pulses and strobes last one cycle unless a state renews them
        next_r.done = 1'b0;
        next_r.nop = 1'b0;
        next_r.mem.we = 1'b0;
        next_r.mem.re = 1'b0;
        unique case (r.state)
            imp_pkg::IMP_IDLE: begin
                // Idle: a pointer load, then at most one instruction
                if (take_load) begin
                    next_r.frame_pointer_reg = fp_value_i;
                end
                if (take_push) begin
                    next_r.mem.we = 1'b1;
                    next_r.mem.addr = r.frame_pointer_reg;
                    next_r.mem.wdata = cmd_i.literal;
                    next_r.frame_pointer_reg = fp_dec;
                    next_r.done = 1'b1;
                end else if (take_move) begin
                    // No memory read for an indirect source
                    next_r.dst_addr = move_dst;
                    next_r.dst_bad = dst_ind;
                    next_r.mem.re = ~src_ind;
                    next_r.mem.addr = move_src;
                    next_r.mem.wdata = `IMP_SRC_ZERO;
                    next_r.state = imp_pkg::IMP_MOVE_RD;
                end
            end
            imp_pkg::IMP_MOVE_RD: begin
                next_r.state = imp_pkg::IMP_MOVE_WR;
            end
            imp_pkg::IMP_MOVE_WR: begin
                // Data returns one cycle after the read strobe
                next_r.mem.addr = r.dst_addr;
                next_r.mem.wdata = move_byte;
                next_r.mem.we = move_we;
                next_r.nop = move_nop;
                next_r.done = 1'b1;
                next_r.state = imp_pkg::IMP_IDLE;
            end
        endcase
        // The read strobe stands through both read cycles
        if (r.state == imp_pkg::IMP_MOVE_RD) begin
            next_r.mem.re = r.mem.re;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            r.state <= imp_pkg::IMP_IDLE;
            r.frame_pointer_reg <= `IMP_FP_RESET;
            r.dst_addr <= 12'h0000;
            r.dst_bad <= 1'b0;
            r.mem <= '0;
            r.done <= 1'b0;
            r.nop <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign mem_o = r.mem;
    assign busy_o = !idle;
    assign done_o = r.done;
    assign nop_o = r.nop;
    assign frame_pointer_reg_o = r.frame_pointer_reg;

endmodule

// file: imp_exec_chk.sv
// Assertion checker for the indexed move and push literal block
module imp_exec_chk (
    input wire logic              clk_i,
    input wire logic              resetn_i,
    input wire imp_pkg::imp_cmd_t cmd_i,
    input wire logic              fp_load_i,
    input wire logic [11:0]       fp_value_i,
    input wire imp_pkg::imp_mem_t mem_o,
    input wire logic [7:0]        mem_rdata_i,
    input wire logic              busy_o,
    input wire logic              done_o,
    input wire logic              nop_o,
    input wire logic [11:0]       frame_pointer_reg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_push; !busy_o && cmd_i.push_go; endsequence
    sequence s_move; !busy_o && !cmd_i.push_go && cmd_i.move_go; endsequence
    a_push_write: assert property (s_push |=> mem_o.we && done_o &&
        mem_o.addr == $past(frame_pointer_reg_o) &&
        mem_o.wdata == $past(cmd_i.literal)) else $error("push store");
    a_push_dec: assert property (s_push |=>
        frame_pointer_reg_o == $past(frame_pointer_reg_o) - 12'h001)
        else $error("push pointer");
    a_move_dest: assert property (s_move |-> ##3 done_o && (nop_o ||
        mem_o.addr == $past(frame_pointer_reg_o, 3) + $past(cmd_i.dst_ofs, 3)))
        else $error("move dest");
    a_move_busy: assert property (s_move |=> busy_o[*2] ##1 !busy_o)
        else $error("move length");
    a_nop_nowrite: assert property (nop_o |-> done_o && !mem_o.we)
        else $error("nop wrote");
endmodule

bind imp_exec imp_exec_chk u_chk (.*);

// file: tb.sv
// Self-checking bench for the indexed move and push literal block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_i = 0;
    logic              resetn_i = 0;
    logic              fp_load_i = 0;
    logic [11:0]       fp_value_i = 0;
    logic [7:0]        mem_rdata_i = 0;
    imp_pkg::imp_cmd_t cmd_i = '0;
    imp_pkg::imp_mem_t mem_o;
    logic              busy_o, done_o, nop_o;
    logic [11:0]       frame_pointer_reg_o, fp, s, t;
    int                n_fail = 0;
    int                samples_checked = 0;
    imp_exec u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_i(cmd_i),
        .fp_load_i(fp_load_i), .fp_value_i(fp_value_i), .mem_o(mem_o),
        .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .done_o(done_o),
        .nop_o(nop_o), .frame_pointer_reg_o(frame_pointer_reg_o));
    initial forever #2 clk_i = ~clk_i;
    function automatic logic ind(logic [11:0] a);
        logic [11:0] r;
        r = a - 12'h0FD9;
        return a >= 12'h0FD9 && a <= 12'h0FEF && r[2:0] <= 3'h4;
    endfunction
    function automatic logic dst_ok(logic [11:0] a);
        return a != 12'h0FF9 && a < 12'h0FFD;
    endfunction
    task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic load(logic [11:0] v);
        fp_load_i = 1;
        fp_value_i = v;
        @(negedge clk_i);
        fp_load_i = 0;
    endtask
    task automatic push(logic [7:0] k);
        fp = frame_pointer_reg_o;
        cmd_i.push_go = 1;
        cmd_i.literal = k;
        @(negedge clk_i);
        chk("push_we", {11'h0, mem_o.we & done_o}, 12'h001);
        chk("push_addr", mem_o.addr, fp);
        chk("push_data", {4'h0, mem_o.wdata}, {4'h0, k});
        chk("push_fp", frame_pointer_reg_o, fp - 12'h001);
    endtask
    task automatic move(logic [6:0] zs, logic [6:0] zd, logic [7:0] v);
        while (!dst_ok(12'(frame_pointer_reg_o + zd)))
            zd = zd + 7'h01;
        s = frame_pointer_reg_o + zs;
        t = frame_pointer_reg_o + zd;
        cmd_i = '{move_go: 1, src_ofs: zs, dst_ofs: zd, default: '0};
        mem_rdata_i = v;
        @(negedge clk_i);
        cmd_i.move_go = 0;
        chk("move_busy", {11'h0, busy_o}, 12'h001);
        chk("move_re", {11'h0, mem_o.re}, {11'h0, !ind(s)});
        chk("move_src", mem_o.addr, s);
        repeat (2) @(negedge clk_i);
        mem_rdata_i = ~v;
        chk("move_done", {11'h0, done_o & !busy_o}, 12'h001);
        chk("move_nop", {11'h0, nop_o & done_o}, {11'h0, ind(t)});
        chk("move_we", {11'h0, mem_o.we}, {11'h0, !ind(t)});
        if (!ind(t))
            chk("move_addr", mem_o.addr, t);
        if (!ind(t))
            chk("move_data", {4'h0, mem_o.wdata},
                {4'h0, (ind(s) ? 8'h00 : v)});
    endtask
    initial begin
        void'($urandom(2723));
        repeat (20) @(negedge clk_i);
        resetn_i = 1;
        load(12'h0001);
        for (int i = 0; i < 16; i++)
            push(8'($urandom));
        cmd_i.push_go = 0;
        $display("push test done");
        load(12'h0FD0);
        move(7'h09, 7'h06, 8'hA5);
        move(7'h00, 7'h11, 8'h3C);
        load(12'h0FF0);
        move(7'h7F, 7'h10, 8'h5A);
        for (int i = 0; i < 60; i++) begin
            load(i[0] ? 12'h0FA0 + 12'($urandom_range(0, 95)) : 12'($urandom));
            move(7'($urandom), 7'($urandom), 8'($urandom));
        end
        $display("move test done");
        close_out();
    end
    initial begin
        #20000;
        n_fail++;
        close_out();
    end
endmodule
